// ---- logic/cfm_fault_monitor.sv ----
// protection, warning and output-ok logic of a point-of-load converter
// How it works
// - thresholds are percentages of the live setpoint, so they follow adjustment and margining.
// - current limit code sits in bits 3:0, reset code 0xB means 140 percent.
// - a written limit code above 0xB is stored as 0xB.
// - warnings never switch the converter off, they only show in status and, for output-ok, on the pin.
// - temperature warning sets above 120 C and clears below 117 C.
// - output-ok pin pulled low outside a 90/95 to 105/110 percent window.
// - window checking starts only once output reaches steady state.
// - output-ok release waits a programmable 0 to 150 ms after steady state.
// - window checking stays on during margining with scaled limits.
// - warning pulls pin low and status flag to 0; recovery restores both.
// - an external low on the output-ok pin raises the warning.
// - turn-off option: pin low at the command or when ramp-down starts.
// - overcurrent, overtemperature, undervoltage or tracking faults switch the output off.
// - overcurrent above pre-bias clears its flag and opens both switches at once.
// - in steady state, undervoltage without overcurrent clears its flag, sequenced ramp-down.
// - above 130 C an overtemperature fault clears its flag, sequenced ramp-down.
// - non-latching overtemperature restarts once temperature is below 120 C.
// - while ramping up with tracking on, 250 mV error trips both switches off.
// - tracking stops once output-ok asserts and margining does not re-arm it.
// - undervoltage field codes 00..11 select 75, 80, 85, 90 percent.
// - non-latching faults retry start-up every 130 ms until the cause clears.
`timescale 1ns/1ps
module cfm_fault_monitor
   import cfm_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
) (
   input  wire logic        clk_i,              // 100 MHz clock
   input  wire logic        arst_n_i,           // async reset, active low
   input  wire logic [7:0]  reg_addr_i,         // register offset
   input  wire logic [7:0]  reg_wdata_i,        // write data
   input  wire logic        reg_we_i,           // write strobe
   input  wire logic        reg_re_i,           // read strobe
   output logic      [7:0]  reg_rdata_o,        // read data, valid after read strobe
   input  wire logic [15:0] vout_mv_i,          // measured output voltage
   input  wire logic [15:0] vset_mv_i,          // present target incl. margining
   input  wire logic [15:0] vramp_mv_i,         // programmed ramp value
   input  wire logic [7:0]  temp_c_i,           // controller temperature
   input  wire logic        oc_trip_i,          // current at limit threshold
   input  wire logic        above_prebias_i,    // output above pre-bias level
   input  wire logic        ramping_up_i,       // sequencer ramping up
   input  wire logic        steady_i,           // output at steady state
   input  wire logic        ramping_down_i,     // output ramping down
   input  wire logic        turn_off_cmd_i,     // turn-off command seen
   input  wire logic        output_ok_pin_i,    // level read back from pin
   output logic             output_ok_out_o,    // pin drive value (always low)
   output logic             output_ok_oe_o,     // pin pulled low when high
   output logic             converter_on_o,     // converter allowed to run
   output logic             fast_off_o,         // both switches opened at once
   output logic             sequenced_off_o,    // regular ramp-down requested
   output logic      [3:0]  limit_code_o,       // effective current limit code
   output logic             temp_comp_en_o,     // current threshold compensation
   output logic      [2:0]  regulation_setting_o // regulation option bits
);

   logic [7:0]  cls_q, pc_q, wc_q, okmode_q, okdelay_q, rdata_q;
   logic        tw_active_q, ok_flag_q, ok_oe_q, track_armed_q;
   logic        oc_flag_q, uv_flag_q, ot_flag_q, tr_flag_q;
   logic [3:0]  cause_q;
   logic        fast_q, seq_q;
   logic [16:0] pre_q;
   logic [7:0]  retry_ms_q, ok_ms_q;
   cfm_state_t  state_q, state_d;

   // register decode
   wire         wr_cls   = reg_we_i && (reg_addr_i == ADDR_CURRENT_LIMIT_SETTING);
   wire         wr_st    = reg_we_i && (reg_addr_i == ADDR_PROTECTION_STATUS);
   wire         wr_pc    = reg_we_i && (reg_addr_i == ADDR_PROTECTION_CONFIG);
   wire         wr_wc    = reg_we_i && (reg_addr_i == ADDR_WINDOW_CONFIG);
   wire         wr_mode  = reg_we_i && (reg_addr_i == ADDR_OUTPUT_OK_MODE);
   wire         wr_delay = reg_we_i && (reg_addr_i == ADDR_OUTPUT_OK_DELAY);
   wire [3:0]   wr_code  = (reg_wdata_i[3:0] > LIMIT_CODE_MAX) ? LIMIT_CODE_MAX
                                                              : reg_wdata_i[3:0];
   wire [7:0]   wr_delay_ms = (reg_wdata_i > OK_DELAY_MAX_MS) ? OK_DELAY_MAX_MS : reg_wdata_i;
   // status bits 1 and 0 belong to protections outside this block and read as no-fault
   wire [7:0]   status = {~tw_active_q, ok_flag_q, tr_flag_q, ot_flag_q,
                          1'b0, uv_flag_q, 1'b1, 1'b1};
   wire [7:0]   rd_mux = (reg_addr_i == ADDR_CURRENT_LIMIT_SETTING) ? cls_q :
                         (reg_addr_i == ADDR_PROTECTION_STATUS)     ? status :
                         (reg_addr_i == ADDR_PROTECTION_CONFIG)     ? pc_q :
                         (reg_addr_i == ADDR_WINDOW_CONFIG)         ? wc_q :
                         (reg_addr_i == ADDR_OUTPUT_OK_MODE)        ? okmode_q :
                         (reg_addr_i == ADDR_OUTPUT_OK_DELAY)       ? okdelay_q : 8'h00;

   // thresholds scale with the live target, so margining moves them too
   wire [23:0]  vout_x100 = {8'h00, vout_mv_i} * PCT_100;
   wire [23:0]  vset_w    = {8'h00, vset_mv_i};
   wire [23:0]  uv_pct    = (wc_q[1:0] == 2'b00) ? PCT_75 :
                            (wc_q[1:0] == 2'b01) ? PCT_80 :
                            (wc_q[1:0] == 2'b10) ? PCT_85 : PCT_90;
   wire [23:0]  hi_pct    = wc_q[WC_HIGH_SEL_BIT] ? PCT_105 : PCT_110;
   wire [23:0]  lo_pct    = wc_q[WC_LOW_SEL_BIT] ? PCT_95 : PCT_90;
   wire [23:0]  uv_lim    = vset_w * uv_pct;
   wire [23:0]  hi_lim    = vset_w * hi_pct;
   wire [23:0]  lo_lim    = vset_w * lo_pct;
   wire         in_window = (vout_x100 >= lo_lim) && (vout_x100 <= hi_lim);
   wire         below_uv  = vout_x100 < uv_lim;

   // tracking error magnitude
   wire [15:0]  track_err = (vout_mv_i > vramp_mv_i) ? (vout_mv_i - vramp_mv_i)
                                                     : (vramp_mv_i - vout_mv_i);

   // fault detection, only while running
   wire         running   = (state_q == FS_RUN);
   wire         hit_oc    = running && oc_trip_i && above_prebias_i;
   wire         hit_uv    = running && steady_i && below_uv && !hit_oc;
   wire         hit_ot    = running && (temp_c_i > TEMP_FAULT);
   wire         hit_tr    = running && ramping_up_i && pc_q[PC_TRACK_EN_BIT] && track_armed_q
                            && (track_err > TRACK_LIMIT_MV);
   wire         any_fault = hit_oc || hit_uv || hit_ot || hit_tr;
   wire [3:0]   hits      = {hit_tr, hit_ot, hit_uv, hit_oc};
   wire         latching  = (hits[0] && pc_q[PC_OC_LATCH_BIT]) || (hits[1] && pc_q[PC_UV_LATCH_BIT]) ||
                            (hits[2] && pc_q[PC_OT_LATCH_BIT]) || (hits[3] && pc_q[PC_TR_LATCH_BIT]);

   // restart conditions
   wire         temp_below_warn = temp_c_i < TEMP_WARN_ON;
   wire         cause_clear = !(cause_q[0] && oc_trip_i) && !(cause_q[2] && !temp_below_warn);
   wire         flags_clear = !((cause_q[0] && !oc_flag_q) || (cause_q[1] && !uv_flag_q) ||
                                (cause_q[2] && !ot_flag_q) || (cause_q[3] && !tr_flag_q));
   wire         ms_tick     = (pre_q == 17'(CYCLES_PER_MS - 1));
   wire         retry_done  = ms_tick && (retry_ms_q >= RETRY_MS - 8'h01);

   always_comb begin
      state_d = state_q;
      case (state_q)
         FS_RUN: begin
            if (any_fault) begin
               state_d = latching ? FS_LATCH : FS_RETRY;
            end
         end
         FS_RETRY: begin
            if (retry_done && cause_clear) begin
               state_d = FS_RUN;
            end
         end
         FS_LATCH: begin
            if (retry_done && cause_clear && flags_clear) begin
               state_d = FS_RUN;
            end
         end
         default: state_d = FS_RUN;
      endcase
   end

   // output-ok: window check after steady state and the release delay
   wire         ok_delay_done = (ok_ms_q >= okdelay_q);
   wire         off_pending   = okmode_q[0] ? turn_off_cmd_i : ramping_down_i;
   wire         ok_window     = running && steady_i && ok_delay_done && in_window
                                && !off_pending;
   wire         ext_low       = !output_ok_pin_i && !ok_oe_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cls_q     <= RST_CURRENT_LIMIT_SETTING;
         pc_q      <= RST_PROTECTION_CONFIG;
         wc_q      <= RST_WINDOW_CONFIG;
         okmode_q  <= RST_OUTPUT_OK_MODE;
         okdelay_q <= RST_OUTPUT_OK_DELAY;
         rdata_q   <= 8'h00;
      end else begin
         if (wr_cls) cls_q <= {reg_wdata_i[7:4], wr_code};
         if (wr_pc) pc_q <= reg_wdata_i;
         if (wr_wc) wc_q <= {2'b00, reg_wdata_i[5:0]};
         if (wr_mode) okmode_q <= {7'h00, reg_wdata_i[0]};
         if (wr_delay) okdelay_q <= wr_delay_ms;
         if (reg_re_i) rdata_q <= rd_mux;
      end
   end

   // fault flags: 0 records an event, host writes 1 to clear uv, ot and tr, the oc flag holds until reset; a new event wins
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oc_flag_q <= 1'b1;
         uv_flag_q <= 1'b1;
         ot_flag_q <= 1'b1;
         tr_flag_q <= 1'b1;
      end else begin
         oc_flag_q <= !hit_oc && (oc_flag_q || (wr_st && reg_wdata_i[0] && 1'b0));
         uv_flag_q <= !hit_uv && (uv_flag_q || (wr_st && reg_wdata_i[ST_UV_BIT]));
         ot_flag_q <= !hit_ot && (ot_flag_q || (wr_st && reg_wdata_i[ST_OT_BIT]));
         tr_flag_q <= !hit_tr && (tr_flag_q || (wr_st && reg_wdata_i[ST_TR_BIT]));
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tw_active_q   <= 1'b0;
         ok_flag_q     <= 1'b0;
         ok_oe_q       <= 1'b1;
         track_armed_q <= 1'b1;
      end else begin
         if (temp_c_i > TEMP_WARN_ON) tw_active_q <= 1'b1;
         else if (temp_c_i < TEMP_WARN_OFF) tw_active_q <= 1'b0;
         ok_oe_q   <= !ok_window;
         ok_flag_q <= ok_window && !ext_low;
         // re-armed only by a fresh start, never by margining
         if (ok_flag_q) track_armed_q <= 1'b0;
         else if (!running || turn_off_cmd_i) track_armed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q    <= FS_RUN;
         cause_q    <= 4'h0;
         fast_q     <= 1'b0;
         seq_q      <= 1'b0;
         pre_q      <= 17'h00000;
         retry_ms_q <= 8'h00;
         ok_ms_q    <= 8'h00;
      end else begin
         state_q <= state_d;
         pre_q   <= ms_tick ? 17'h00000 : pre_q + 17'h00001;
         if (running && any_fault) begin
            cause_q <= hits;
            fast_q  <= hit_oc || hit_tr;
            seq_q   <= !(hit_oc || hit_tr);
         end else if (state_d == FS_RUN) begin
            fast_q <= 1'b0;
            seq_q  <= 1'b0;
         end
         // retry period restarts on entry and after each failed attempt
         if (running || retry_done) retry_ms_q <= 8'h00;
         else if (ms_tick) retry_ms_q <= retry_ms_q + 8'h01;
         // ms granularity: release lands up to 1 ms before the programmed delay
         if (!(running && steady_i)) ok_ms_q <= 8'h00;
         else if (ms_tick && !ok_delay_done) ok_ms_q <= ok_ms_q + 8'h01;
      end
   end

   assign reg_rdata_o          = rdata_q;
   assign output_ok_out_o      = 1'b0;
   assign output_ok_oe_o       = ok_oe_q;
   assign converter_on_o       = running;
   assign fast_off_o           = fast_q;
   assign sequenced_off_o      = seq_q;
   assign limit_code_o         = cls_q[3:0];
   assign temp_comp_en_o       = cls_q[CLS_TCE_BIT];
   assign regulation_setting_o = cls_q[7:5];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_limit_clamp: assert property (wr_cls |=> cls_q[3:0] <= LIMIT_CODE_MAX)
      else $error("limit code above maximum");
   chk_oc_flag_low: assert property (hit_oc |=> !oc_flag_q && fast_off_o && !converter_on_o)
      else $error("overcurrent not recorded");
   chk_uv_sequenced: assert property (hit_uv |=> !uv_flag_q ##0 sequenced_off_o)
      else $error("undervoltage not sequenced");
   chk_ot_fault: assert property (running && temp_c_i > TEMP_FAULT |=> !converter_on_o && !ot_flag_q)
      else $error("overtemperature did not stop output");
   chk_tw_hyst: assert property ($rose(tw_active_q) |-> $past(temp_c_i) > TEMP_WARN_ON)
      else $error("warning without hot temperature");
   chk_ok_window: assert property (!ok_window |=> output_ok_oe_o && !ok_flag_q)
      else $error("output-ok not pulled low");
   chk_ok_steady: assert property (!steady_i |=> output_ok_oe_o)
      else $error("output-ok released before steady state");
   chk_tr_disarm: assert property (ok_flag_q |=> !track_armed_q)
      else $error("tracking still armed after output-ok");
   chk_warn_no_off: assert property (running && !any_fault |=> converter_on_o)
      else $error("converter off without fault");
   chk_retry_hold: assert property (state_q == FS_RETRY && !retry_done |=> state_q != FS_RUN)
      else $error("restart before retry period");

   cov_oc_trip: cover property (hit_oc);
   cov_retry_restart: cover property (state_q == FS_RETRY ##1 state_q == FS_RUN);
   cov_ok_release: cover property ($fell(output_ok_oe_o));
   cov_ext_low: cover property (ext_low);
   cov_track_trip: cover property (hit_tr);

   // warnings
   chk_tw_set: assert property (temp_c_i > TEMP_WARN_ON |=> tw_active_q)
      else $error("warning not raised when hot");
   chk_tw_clear: assert property (temp_c_i < TEMP_WARN_OFF |=> !tw_active_q)
      else $error("warning not removed when cool");

   // output-ok pin and flag
   chk_ok_ext_low: assert property (ext_low |=> !ok_flag_q)
      else $error("external low did not clear output-ok flag");
   chk_pin_drive: assert property (output_ok_out_o == 1'b0)
      else $error("output-ok pin driven high");
   chk_win_high: assert property (running && steady_i && vout_x100 > hi_lim |=> output_ok_oe_o)
      else $error("output-ok released above window");
   chk_win_low: assert property (running && steady_i && vout_x100 < lo_lim |=> output_ok_oe_o)
      else $error("output-ok released below window");
   chk_off_pending: assert property (running && off_pending |=> output_ok_oe_o)
      else $error("output-ok released while turning off");
   chk_delay_clamp: assert property (okdelay_q <= OK_DELAY_MAX_MS)
      else $error("release delay above maximum");

   // limit register
   chk_limit_out: assert property (limit_code_o <= LIMIT_CODE_MAX)
      else $error("effective limit code above maximum");

   // faults and shutdown style
   chk_fault_off: assert property (any_fault |=> !converter_on_o)
      else $error("fault did not switch output off");
   chk_tr_fast: assert property (hit_tr |=> !tr_flag_q && fast_off_o && !converter_on_o)
      else $error("tracking fault not fast off");
   chk_tr_disabled: assert property (!pc_q[PC_TRACK_EN_BIT] |-> !hit_tr)
      else $error("tracking fault while disabled");
   chk_ot_seq: assert property (hit_ot && !hit_oc && !hit_tr |=> sequenced_off_o)
      else $error("overtemperature not sequenced");
   chk_uv_steady: assert property (!steady_i |-> !hit_uv)
      else $error("undervoltage outside steady state");
   chk_oc_sticky: assert property (!oc_flag_q |=> !oc_flag_q)
      else $error("overcurrent record lost");

   // flag clearing and restart
   chk_uv_clear: assert property (wr_st && reg_wdata_i[ST_UV_BIT] && !hit_uv |=> uv_flag_q)
      else $error("undervoltage flag not cleared");
   chk_ot_clear: assert property (wr_st && reg_wdata_i[ST_OT_BIT] && !hit_ot |=> ot_flag_q)
      else $error("overtemperature flag not cleared");
   chk_set_wins: assert property (hit_uv && wr_st && reg_wdata_i[ST_UV_BIT] |=> !uv_flag_q)
      else $error("clear beat a new undervoltage event");
   chk_ot_restart: assert property (state_q == FS_RETRY && cause_q[2] && !temp_below_warn
                                    |=> state_q != FS_RUN)
      else $error("restart while still warm");
   chk_latch_hold: assert property (state_q == FS_LATCH && !flags_clear |=> state_q != FS_RUN)
      else $error("latched fault restarted with flag set");

endmodule // cfm_fault_monitor

// ---- logic/cfm_pkg.sv ----
// constants, register map and types for the converter fault monitor
package cfm_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CURRENT_LIMIT_SETTING = 8'h08;
   localparam logic [7:0] ADDR_PROTECTION_STATUS     = 8'h16;
   localparam logic [7:0] ADDR_PROTECTION_CONFIG     = 8'h20;
   localparam logic [7:0] ADDR_WINDOW_CONFIG         = 8'h21;
   localparam logic [7:0] ADDR_OUTPUT_OK_MODE        = 8'h30;
   localparam logic [7:0] ADDR_OUTPUT_OK_DELAY       = 8'h31;
   // reset values
   localparam logic [7:0] RST_CURRENT_LIMIT_SETTING  = 8'h1B;
   localparam logic [7:0] RST_PROTECTION_CONFIG      = 8'h01;
   localparam logic [7:0] RST_WINDOW_CONFIG          = 8'h08;
   localparam logic [7:0] RST_OUTPUT_OK_MODE         = 8'h00;
   localparam logic [7:0] RST_OUTPUT_OK_DELAY        = 8'h00;
   // current limit setting fields
   localparam int         CLS_TCE_BIT                = 4;
   localparam logic [3:0] LIMIT_CODE_MAX             = 4'hB;
   // protection_config fields
   localparam int         PC_TRACK_EN_BIT            = 7;
   localparam int         PC_TR_LATCH_BIT            = 5;
   localparam int         PC_OT_LATCH_BIT            = 4;
   localparam int         PC_OC_LATCH_BIT            = 3;
   localparam int         PC_UV_LATCH_BIT            = 2;
   // window config fields
   localparam int         WC_HIGH_SEL_BIT            = 5;
   localparam int         WC_LOW_SEL_BIT             = 4;
   // status fields
   localparam int         ST_TW_BIT                  = 7;
   localparam int         ST_PG_BIT                  = 6;
   localparam int         ST_TR_BIT                  = 5;
   localparam int         ST_OT_BIT                  = 4;
   localparam int         ST_UV_BIT                  = 2;
   // percentages of setpoint, 24 bits to meet the products
   localparam logic [23:0] PCT_100 = 24'h64;
   localparam logic [23:0] PCT_75  = 24'h4B;
   localparam logic [23:0] PCT_80  = 24'h50;
   localparam logic [23:0] PCT_85  = 24'h55;
   localparam logic [23:0] PCT_90  = 24'h5A;
   localparam logic [23:0] PCT_95  = 24'h5F;
   localparam logic [23:0] PCT_105 = 24'h69;
   localparam logic [23:0] PCT_110 = 24'h6E;
   // temperatures in degrees C, voltage in mV
   localparam logic [7:0]  TEMP_WARN_ON   = 8'h78;
   localparam logic [7:0]  TEMP_WARN_OFF  = 8'h75;
   localparam logic [7:0]  TEMP_FAULT     = 8'h82;
   localparam logic [15:0] TRACK_LIMIT_MV = 16'h00FA;
   // timing
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          MS_IN_NS       = 1000000;
   localparam int          CYC_PER_MS     = MS_IN_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  RETRY_MS       = 8'h82;
   localparam logic [7:0]  OK_DELAY_MAX_MS = 8'h96;

   typedef enum logic [1:0] {
      FS_RUN   = 2'b00,
      FS_RETRY = 2'b01,
      FS_LATCH = 2'b11
   } cfm_state_t;
endpackage

// ---- bench/cfm_host_model.sv ----
// host power manager model: register reads and writes over the strobe port
`timescale 1ns/1ps
module cfm_host_model
   import cfm_pkg::*;
(
   input  wire logic       clk_i,    // device clock
   input  wire logic [7:0] rdata_i,  // read data from the device
   output logic      [7:0] addr_o,   // register offset
   output logic      [7:0] wdata_o,  // write data
   output logic            we_o,     // write strobe
   output logic            re_o      // read strobe
);
   initial {addr_o, wdata_o, we_o, re_o} = '0;
   // one strobe cycle per access; offset and data are scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      {addr_o, wdata_o, we_o} <= {a, v, 1'b1};
      @(posedge clk_i);
      {addr_o, wdata_o, we_o} <= {~a, ~v, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      {addr_o, re_o} <= {a, 1'b1};
      @(posedge clk_i);
      {addr_o, re_o} <= {~a, 1'b0};
      #1 v = rdata_i;
   endtask
   // regulation bits share the limit register, so only the code is rewritten
   task automatic set_limit(input logic [3:0] code);
      logic [7:0] v;
      rd(ADDR_CURRENT_LIMIT_SETTING, v);
      wr(ADDR_CURRENT_LIMIT_SETTING, {v[7:4], code});
   endtask
endmodule  // cfm_host_model

// ---- bench/tb.sv ----
// self-checking bench of the converter fault monitor
`timescale 1ns/1ps
module tb
   import cfm_pkg::*;
;
   logic        clk_i, arst_n_i, oc_trip_i, above_prebias_i, ramping_up_i, steady_i, ramping_down_i;
   logic        turn_off_cmd_i, ext_low, reg_we_i, reg_re_i, output_ok_out_o, output_ok_oe_o;
   logic        converter_on_o, fast_off_o, sequenced_off_o, temp_comp_en_o;
   logic [2:0]  regulation_setting_o;
   logic [3:0]  limit_code_o;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, temp_c_i, d, run_st;
   logic [15:0] vout_mv_i, vset_mv_i, vramp_mv_i;
   logic [31:0] rnd;
   int          mismatches, samples_checked, cls_m;
   // open-drain pin with pull-up: low when the device or an outside circuit pulls it
   wire         output_ok_pin_i = ~(output_ok_oe_o | ext_low);
   assign run_st = {5'h00, converter_on_o, fast_off_o, sequenced_off_o};
   cfm_fault_monitor #(.CYCLES_PER_MS(10)) i_dut (
      .clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .vout_mv_i,
      .vset_mv_i, .vramp_mv_i, .temp_c_i, .oc_trip_i, .above_prebias_i, .ramping_up_i, .steady_i,
      .ramping_down_i, .turn_off_cmd_i, .output_ok_pin_i, .output_ok_out_o, .output_ok_oe_o,
      .converter_on_o, .fast_off_o, .sequenced_off_o, .limit_code_o, .temp_comp_en_o, .regulation_setting_o
   );
   cfm_host_model i_host (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
      .we_o(reg_we_i), .re_o(reg_re_i));
   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_status(input int b, input logic e);
      repeat (2) @(posedge clk_i);
      i_host.rd(ADDR_PROTECTION_STATUS, d);
      chk({7'h00, d[b]}, {7'h00, e});
   endtask
   // waits for the pin to be released (pin_side) or for the converter to run again
   task automatic wait_lvl(input logic pin_side, input int lim);
      for (int i = 0; i < lim && (pin_side ? output_ok_oe_o : !converter_on_o) !== 1'b0; i++) @(posedge clk_i) #1;
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #300000;
      mismatches++;
      give_verdict();
   end
   initial begin
      {arst_n_i, oc_trip_i, ramping_up_i, steady_i, ramping_down_i, turn_off_cmd_i, ext_low} = '0;
      above_prebias_i = 1'b1;
      {vout_mv_i, vset_mv_i, vramp_mv_i} = {16'h0000, 16'h03E8, 16'h0000};
      temp_c_i = 8'h19;
      rnd = 32'h8F91;
      repeat (4) @(posedge clk_i);
      arst_n_i <= 1'b1;
      i_host.rd(ADDR_CURRENT_LIMIT_SETTING, d);
      chk(d, 8'h1B);
      i_host.rd(ADDR_PROTECTION_STATUS, d);
      chk(d, 8'hB7);
      i_host.rd(8'h7F, d);
      chk(d, 8'h00);
      rnd = lfsr(rnd);
      i_host.wr(ADDR_CURRENT_LIMIT_SETTING, {rnd[2:0], 5'h1B});
      for (int c = 0; c < 16; c++) begin
         i_host.set_limit(c[3:0]);
         cls_m = rnd[2:0] * 32 + 16 + ((c > 11) ? 11 : c);
         i_host.rd(ADDR_CURRENT_LIMIT_SETTING, d);
         chk(d, cls_m[7:0]);
         chk({limit_code_o, regulation_setting_o, temp_comp_en_o}, {cls_m[3:0], cls_m[7:5], cls_m[4]});
      end
      temp_c_i <= 8'h79;
      chk_status(ST_TW_BIT, 1'b0);
      chk(run_st, 8'h04);
      temp_c_i <= 8'h76;
      chk_status(ST_TW_BIT, 1'b0);
      temp_c_i <= 8'h74;
      chk_status(ST_TW_BIT, 1'b1);
      i_host.wr(ADDR_OUTPUT_OK_DELAY, 8'hC8);
      i_host.rd(ADDR_OUTPUT_OK_DELAY, d);
      chk(d, 8'h96);
      i_host.wr(ADDR_OUTPUT_OK_DELAY, 8'h05);
      vout_mv_i <= 16'h03E8;
      repeat (20) @(posedge clk_i);
      #1 chk({7'h00, output_ok_oe_o}, 8'h01);
      @(posedge clk_i);
      steady_i <= 1'b1;
      // release can come as early as 42 edges after steady, so look before that
      repeat (35) @(posedge clk_i);
      #1 chk({7'h00, output_ok_oe_o}, 8'h01);
      wait_lvl(1'b1, 30);
      chk({7'h00, output_ok_oe_o}, 8'h00);
      chk_status(ST_PG_BIT, 1'b1);
      // margining up: 1000 mV is now 87 percent of the target
      vset_mv_i <= 16'h047E;
      repeat (3) @(posedge clk_i);
      #1 chk({7'h00, output_ok_oe_o}, 8'h01);
      chk_status(ST_PG_BIT, 1'b0);
      vset_mv_i <= 16'h03E8;
      wait_lvl(1'b1, 80);
      chk({7'h00, output_ok_oe_o}, 8'h00);
      ext_low <= 1'b1;
      chk_status(ST_PG_BIT, 1'b0);
      chk({7'h00, output_ok_oe_o}, 8'h00);
      ext_low <= 1'b0;
      wait_lvl(1'b1, 10);
      ramping_down_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk({7'h00, output_ok_oe_o}, 8'h01);
      chk({7'h00, output_ok_out_o}, 8'h00);
      i_host.wr(ADDR_OUTPUT_OK_MODE, 8'h01);
      wait_lvl(1'b1, 10);
      chk({7'h00, output_ok_oe_o}, 8'h00);
      turn_off_cmd_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk({7'h00, output_ok_oe_o}, 8'h01);
      {ramping_down_i, turn_off_cmd_i} <= 2'b00;
      @(posedge clk_i);
      oc_trip_i <= 1'b1;
      @(posedge clk_i);
      #1 chk(run_st, 8'h02);
      oc_trip_i <= 1'b0;
      repeat (1000) @(posedge clk_i);
      #1 chk(run_st, 8'h02);
      wait_lvl(1'b0, 500);
      chk(run_st, 8'h04);
      @(posedge clk_i);
      temp_c_i <= 8'h83;
      @(posedge clk_i);
      #1 chk(run_st, 8'h01);
      chk_status(ST_OT_BIT, 1'b0);
      temp_c_i <= 8'h7D;
      repeat (1500) @(posedge clk_i);
      #1 chk(run_st, 8'h01);
      temp_c_i <= 8'h77;
      wait_lvl(1'b0, 1500);
      chk(run_st, 8'h04);
      i_host.wr(ADDR_PROTECTION_STATUS, 8'h34);
      chk_status(ST_OT_BIT, 1'b1);
      for (int u = 0; u < 4; u++) begin
         i_host.wr(ADDR_WINDOW_CONFIG, 8'h08 | u[7:0]);
         vout_mv_i <= 16'((75 + 5 * u) * 10 + 5);
         repeat (3) @(posedge clk_i);
         #1 chk(run_st, 8'h04);
         vout_mv_i <= 16'((75 + 5 * u) * 10 - 5);
         repeat (2) @(posedge clk_i);
         #1 chk(run_st, 8'h01);
         chk_status(ST_UV_BIT, 1'b0);
         vout_mv_i <= 16'h03E8;
         i_host.wr(ADDR_PROTECTION_STATUS, 8'h34);
         wait_lvl(1'b0, 1500);
      end
      {steady_i, ramping_up_i, vramp_mv_i, vout_mv_i} <= {2'b01, 16'h01F4, 16'h0320};
      repeat (3) @(posedge clk_i);
      #1 chk(run_st, 8'h04);
      i_host.wr(ADDR_PROTECTION_CONFIG, 8'h81);
      repeat (2) @(posedge clk_i);
      #1 chk(run_st, 8'h02);
      chk_status(ST_TR_BIT, 1'b0);
      give_verdict();
   end
endmodule  // tb
